// ### design/pll_divider_word_decode.sv
// decoder of the three divider programming words of the dual loop synthesizer
`timescale 1ns/1ps

// Notes on behaviour
// - main feedback word is recognised by bit 0 being zero
// - main word: 11-bit divide at 23:13, 12-bit numerator at 12:1
// - main divide field is used directly as the binary divide value
// - word 0001: denominator, 6-bit reference divide, power-down at 23, bit 22 one
// - main reference divider divides by its 6-bit value, 1 to 63
// - main power-down bit one stops the loop and floats its pump
// - enable pin low wins, then auto power-up, then power-down bit
// - aux divider: swallow is the field's low 4 bits (low 3 with 8/9), program count is field bits 16:4 for both prescalers
// - aux field is binary N; fourth bit unused and zero with 8/9
// - aux pump gain zero gives 1 mA, one gives 4 mA
// - aux prescaler select zero picks 8/9, one picks 16/17
// - aux power-down one stops the aux loop and floats its pump
module pll_divider_word_decode (
  // clock and reset
  input  wire logic                                ref_clk,
  input  wire logic                                rst_b,
  // serial link pins
  input  wire logic                                link_clk,
  input  wire logic                                link_data,
  input  wire logic                                link_load,
  // chip enable pin and settings from other words
  input  wire logic                                chip_enable,
  input  wire logic                                auto_power_up_field,
  input  wire logic [1:0]                          modulator_order,
  // main loop settings
  output logic      [pll_word_pkg::MAIN_N_W-1:0]   main_feedback_count,
  output logic      [pll_word_pkg::FRAC_W-1:0]     main_fraction_numerator,
  output logic      [pll_word_pkg::FRAC_W-1:0]     main_fraction_denominator,
  output logic      [pll_word_pkg::REF_W-1:0]      main_reference_count,
  output logic                                     main_loop_power_down,
  output logic                                     main_loop_active,
  output logic                                     main_pump_tristate,
  output logic                                     main_count_illegal,
  // aux loop settings
  output logic      [pll_word_pkg::AUX_N_W-1:0]    aux_feedback_count,
  output logic      [pll_word_pkg::AUX_B_W-1:0]    aux_program_count,
  output logic      [pll_word_pkg::AUX_A_W-1:0]    aux_swallow_count,
  output logic                                     aux_prescaler_16,
  output logic                                     aux_pump_gain,
  output logic                                     aux_pump_high_current,
  output logic                                     aux_loop_power_down,
  output logic                                     aux_pump_tristate,
  output logic                                     aux_count_illegal,
  // load events
  output logic                                     main_word_loaded,
  output logic                                     ref_word_loaded,
  output logic                                     aux_word_loaded
);

  ////////////////////////////////////////////////////////////////////////////
  // link side

  logic [pll_word_pkg::WORD_W-1:0]      shift_word;
  logic [pll_word_pkg::SHIFT_CNT_W-1:0] bit_count;
  logic [pll_word_pkg::SYNC_W-1:0]      pin_async;
  logic [pll_word_pkg::SYNC_W-1:0]      pin_sync;

  serial_word_shifter u_shifter (
    .link_clk   (link_clk),
    .rst_b      (rst_b),
    .link_data  (link_data),
    .link_load  (link_load),
    .shift_word (shift_word),
    .bit_count  (bit_count)
  );

  assign pin_async[pll_word_pkg::SYNC_LOAD]   = link_load;
  assign pin_async[pll_word_pkg::SYNC_ENABLE] = chip_enable;

  level_sync u_sync (
    .ref_clk  (ref_clk),
    .rst_b    (rst_b),
    .async_in (pin_async),
    .sync_out (pin_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // load strobe edge

  logic load_seen;
  logic next_load_seen;
  logic load_rise;
  logic enable_sync;

  assign enable_sync = pin_sync[pll_word_pkg::SYNC_ENABLE];

  always_comb begin
    next_load_seen = pin_sync[pll_word_pkg::SYNC_LOAD];
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      load_seen <= 1'h0;
    end else begin
      load_seen <= next_load_seen;
    end
  end

  // the shift word is held still while the strobe is high, since the shifter
  // does not shift then; it is sampled only after the strobe is synced
  assign load_rise = pin_sync[pll_word_pkg::SYNC_LOAD] & ~load_seen;

  ////////////////////////////////////////////////////////////////////////////
  // address decode

  logic                             full_word;
  logic                             hit_main;
  logic                             hit_ref;
  logic                             hit_aux;
  logic [pll_word_pkg::ADDR_MSB:0]  addr_code;

  assign addr_code = shift_word[pll_word_pkg::ADDR_MSB:pll_word_pkg::ADDR_LSB];
  // a frame is taken only once 24 bits have shifted since reset; the bit count is never cleared
  assign full_word = (bit_count == pll_word_pkg::SHIFT_CNT_W'(pll_word_pkg::WORD_W));

  assign hit_main = load_rise & full_word &
                    (shift_word[pll_word_pkg::MAIN_ADDR_BIT] == pll_word_pkg::MAIN_ADDR_CODE);
  assign hit_ref  = load_rise & full_word & (addr_code == pll_word_pkg::REF_ADDR_CODE);
  assign hit_aux  = load_rise & full_word & (addr_code == pll_word_pkg::AUX_ADDR_CODE);

  ////////////////////////////////////////////////////////////////////////////
  // main feedback divider word

  logic [pll_word_pkg::MAIN_N_W-1:0] next_main_feedback_count;
  logic [pll_word_pkg::FRAC_W-1:0]   next_main_fraction_numerator;

  always_comb begin
    next_main_feedback_count     = main_feedback_count;
    next_main_fraction_numerator = main_fraction_numerator;
    if (hit_main) begin
      next_main_feedback_count     = shift_word[pll_word_pkg::MAIN_N_LSB +: pll_word_pkg::MAIN_N_W];
      next_main_fraction_numerator = shift_word[pll_word_pkg::FRAC_NUM_LSB +: pll_word_pkg::FRAC_W];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      main_feedback_count     <= pll_word_pkg::MAIN_N_RESET;
      main_fraction_numerator <= pll_word_pkg::FRAC_NUM_RESET;
    end else begin
      main_feedback_count     <= next_main_feedback_count;
      main_fraction_numerator <= next_main_fraction_numerator;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // main reference and denominator word

  logic [pll_word_pkg::FRAC_W-1:0] next_main_fraction_denominator;
  logic [pll_word_pkg::REF_W-1:0]  next_main_reference_count;
  logic                            main_pd_bit;
  logic                            next_main_pd_bit;

  always_comb begin
    next_main_fraction_denominator = main_fraction_denominator;
    next_main_reference_count      = main_reference_count;
    next_main_pd_bit               = main_pd_bit;
    if (hit_ref) begin
      next_main_fraction_denominator = shift_word[pll_word_pkg::FRAC_DEN_LSB +: pll_word_pkg::FRAC_W];
      next_main_pd_bit               = shift_word[pll_word_pkg::MAIN_PD_BIT];
      if (shift_word[pll_word_pkg::REF_LSB +: pll_word_pkg::REF_W] != '0) begin
        next_main_reference_count = shift_word[pll_word_pkg::REF_LSB +: pll_word_pkg::REF_W];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      main_fraction_denominator <= pll_word_pkg::FRAC_DEN_RESET;
      main_reference_count      <= pll_word_pkg::REF_RESET;
      main_pd_bit               <= pll_word_pkg::PD_RESET;
    end else begin
      main_fraction_denominator <= next_main_fraction_denominator;
      main_reference_count      <= next_main_reference_count;
      main_pd_bit               <= next_main_pd_bit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // main power-down precedence

  logic next_main_loop_power_down;

  always_comb begin
    if (!enable_sync) begin
      next_main_loop_power_down = 1'h1;
    end else if (auto_power_up_field) begin
      next_main_loop_power_down = 1'h0;
    end else begin
      next_main_loop_power_down = main_pd_bit;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      main_loop_power_down <= pll_word_pkg::PD_RESET;
    end else begin
      main_loop_power_down <= next_main_loop_power_down;
    end
  end

  assign main_loop_active   = ~main_loop_power_down;
  assign main_pump_tristate = main_loop_power_down;

  ////////////////////////////////////////////////////////////////////////////
  // main divide legality, reported only: the divider still takes the value

  logic next_main_count_illegal;

  always_comb begin
    next_main_count_illegal = 1'h0;
    if ((main_feedback_count <= pll_word_pkg::MAIN_N_PROHIB_LOW) ||
        (main_feedback_count > pll_word_pkg::MAIN_N_PROHIB_HIGH)) begin
      next_main_count_illegal = 1'h1;
    end else if ((main_feedback_count == pll_word_pkg::MAIN_N_ORD2_LOW) ||
                 (main_feedback_count >= pll_word_pkg::MAIN_N_ORD2_HIGH)) begin
      next_main_count_illegal = (modulator_order != pll_word_pkg::ORDER_2);
    end else if ((main_feedback_count == pll_word_pkg::MAIN_N_ORD23_LOW) ||
                 (main_feedback_count >= pll_word_pkg::MAIN_N_ORD23_HIGH)) begin
      next_main_count_illegal = (modulator_order != pll_word_pkg::ORDER_2) &&
                                (modulator_order != pll_word_pkg::ORDER_3);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      main_count_illegal <= 1'h1;
    end else begin
      main_count_illegal <= next_main_count_illegal;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // aux loop word

  logic [pll_word_pkg::AUX_N_W-1:0] next_aux_feedback_count;
  logic                             next_aux_prescaler_16;
  logic                             next_aux_pump_gain;
  logic                             next_aux_loop_power_down;

  always_comb begin
    next_aux_feedback_count  = aux_feedback_count;
    next_aux_prescaler_16    = aux_prescaler_16;
    next_aux_pump_gain       = aux_pump_gain;
    next_aux_loop_power_down = aux_loop_power_down;
    if (hit_aux) begin
      next_aux_feedback_count  = shift_word[pll_word_pkg::AUX_N_LSB +: pll_word_pkg::AUX_N_W];
      next_aux_prescaler_16    = shift_word[pll_word_pkg::AUX_PRESC_BIT];
      next_aux_pump_gain       = shift_word[pll_word_pkg::AUX_GAIN_BIT];
      next_aux_loop_power_down = shift_word[pll_word_pkg::AUX_PD_BIT];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      aux_feedback_count  <= pll_word_pkg::AUX_N_RESET;
      aux_prescaler_16    <= pll_word_pkg::AUX_PRESC_RESET;
      aux_pump_gain       <= pll_word_pkg::AUX_GAIN_RESET;
      aux_loop_power_down <= pll_word_pkg::PD_RESET;
    end else begin
      aux_feedback_count  <= next_aux_feedback_count;
      aux_prescaler_16    <= next_aux_prescaler_16;
      aux_pump_gain       <= next_aux_pump_gain;
      aux_loop_power_down <= next_aux_loop_power_down;
    end
  end

  assign aux_pump_high_current = (aux_pump_gain != pll_word_pkg::GAIN_LOW_1MA);
  assign aux_pump_tristate     = aux_loop_power_down;

  ////////////////////////////////////////////////////////////////////////////
  // aux dual-modulus split

  logic [pll_word_pkg::AUX_B_W-1:0] next_aux_program_count;
  logic [pll_word_pkg::AUX_A_W-1:0] next_aux_swallow_count;
  logic                             next_aux_count_illegal;

  always_comb begin
    next_aux_program_count = aux_feedback_count[pll_word_pkg::AUX_N_W-1:pll_word_pkg::AUX_A_W];
    if (aux_prescaler_16 == pll_word_pkg::PRESC_8) begin
      next_aux_swallow_count = {1'h0, aux_feedback_count[pll_word_pkg::AUX_A8_MSB:0]};
    end else begin
      next_aux_swallow_count = aux_feedback_count[pll_word_pkg::AUX_A_W-1:0];
    end
    next_aux_count_illegal = (next_aux_program_count < pll_word_pkg::AUX_B_MIN) ||
                             (next_aux_program_count < pll_word_pkg::AUX_B_W'(next_aux_swallow_count));
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      aux_program_count <= '0;
      aux_swallow_count <= '0;
      aux_count_illegal <= 1'h1;
    end else begin
      aux_program_count <= next_aux_program_count;
      aux_swallow_count <= next_aux_swallow_count;
      aux_count_illegal <= next_aux_count_illegal;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // load event pulses

  logic next_main_word_loaded;
  logic next_ref_word_loaded;
  logic next_aux_word_loaded;

  always_comb begin
    next_main_word_loaded = hit_main;
    next_ref_word_loaded  = hit_ref;
    next_aux_word_loaded  = hit_aux;
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      main_word_loaded <= 1'h0;
      ref_word_loaded  <= 1'h0;
      aux_word_loaded  <= 1'h0;
    end else begin
      main_word_loaded <= next_main_word_loaded;
      ref_word_loaded  <= next_ref_word_loaded;
      aux_word_loaded  <= next_aux_word_loaded;
    end
  end

endmodule

// ### design/pll_word_pkg.sv
// constants for the divider programming word decoder
package pll_word_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // word geometry
  localparam int unsigned WORD_W       = 24;
  localparam int unsigned SHIFT_CNT_W  = 5;
  localparam int unsigned SYNC_W       = 2;
  localparam int unsigned SYNC_LOAD    = 0;
  localparam int unsigned SYNC_ENABLE  = 1;

  ////////////////////////////////////////////////////////////////////////////
  // address codes
  localparam int unsigned MAIN_ADDR_BIT  = 0;
  localparam logic        MAIN_ADDR_CODE = 1'h0;
  localparam int unsigned ADDR_LSB       = 0;
  localparam int unsigned ADDR_MSB       = 3;
  localparam logic [3:0]  REF_ADDR_CODE  = 4'h1;
  localparam logic [3:0]  AUX_ADDR_CODE  = 4'h3;

  ////////////////////////////////////////////////////////////////////////////
  // main feedback divider word
  localparam int unsigned MAIN_N_W       = 11;
  localparam int unsigned MAIN_N_LSB     = 13;
  localparam int unsigned FRAC_W         = 12;
  localparam int unsigned FRAC_NUM_LSB   = 1;

  // main reference and denominator word
  localparam int unsigned FRAC_DEN_LSB   = 4;
  localparam int unsigned REF_W          = 6;
  localparam int unsigned REF_LSB        = 16;
  localparam int unsigned REF_FIXED_BIT  = 22;
  localparam int unsigned MAIN_PD_BIT    = 23;

  // aux loop word
  localparam int unsigned AUX_N_W        = 17;
  localparam int unsigned AUX_N_LSB      = 4;
  localparam int unsigned AUX_GAIN_BIT   = 21;
  localparam int unsigned AUX_PRESC_BIT  = 22;
  localparam int unsigned AUX_PD_BIT     = 23;
  localparam int unsigned AUX_B_W        = 13;
  localparam int unsigned AUX_A_W        = 4;
  localparam int unsigned AUX_A8_MSB     = 2;

  ////////////////////////////////////////////////////////////////////////////
  // legal divide limits
  localparam logic [10:0] MAIN_N_PROHIB_LOW  = 11'h041;
  localparam logic [10:0] MAIN_N_ORD2_LOW    = 11'h042;
  localparam logic [10:0] MAIN_N_ORD23_LOW   = 11'h043;
  localparam logic [10:0] MAIN_N_ORD23_HIGH  = 11'h7f9;
  localparam logic [10:0] MAIN_N_ORD2_HIGH   = 11'h7fd;
  localparam logic [10:0] MAIN_N_PROHIB_HIGH = 11'h7fe;
  localparam logic [1:0]  ORDER_2            = 2'h1;
  localparam logic [1:0]  ORDER_3            = 2'h2;
  localparam logic [12:0] AUX_B_MIN          = 13'h0003;

  ////////////////////////////////////////////////////////////////////////////
  // values after reset
  localparam logic [10:0] MAIN_N_RESET       = 11'h000;
  localparam logic [11:0] FRAC_NUM_RESET     = 12'h000;
  localparam logic [11:0] FRAC_DEN_RESET     = 12'h000;
  localparam logic [5:0]  REF_RESET          = 6'h01;
  localparam logic        PD_RESET           = 1'h1;
  localparam logic [16:0] AUX_N_RESET        = 17'h00000;
  localparam logic        AUX_PRESC_RESET    = 1'h0;
  localparam logic        AUX_GAIN_RESET     = 1'h0;

  localparam logic        PRESC_8            = 1'h0;
  localparam logic        GAIN_LOW_1MA       = 1'h0;

endpackage

// ### design/level_sync.sv
// two flip-flop synchroniser for the pin levels
`timescale 1ns/1ps
module level_sync (
  // clock and reset
  input  wire logic                              ref_clk,
  input  wire logic                              rst_b,
  // levels
  input  wire logic [pll_word_pkg::SYNC_W-1:0]   async_in,
  output logic      [pll_word_pkg::SYNC_W-1:0]   sync_out
);

  logic [pll_word_pkg::SYNC_W-1:0] stage1;
  logic [pll_word_pkg::SYNC_W-1:0] next_stage1;
  logic [pll_word_pkg::SYNC_W-1:0] next_sync_out;

  ////////////////////////////////////////////////////////////////////////////
  // stage one is read by stage two only
  always_comb begin
    next_stage1   = async_in;
    next_sync_out = stage1;
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      stage1   <= '0;
      sync_out <= '0;
    end else begin
      stage1   <= next_stage1;
      sync_out <= next_sync_out;
    end
  end

endmodule

// ### design/serial_word_shifter.sv
// serial shift register on the link clock
`timescale 1ns/1ps
module serial_word_shifter (
  // link clock and reset
  input  wire logic                              link_clk,
  input  wire logic                              rst_b,
  // serial pins
  input  wire logic                              link_data,
  input  wire logic                              link_load,
  // captured word
  output logic      [pll_word_pkg::WORD_W-1:0]   shift_word,
  output logic      [pll_word_pkg::SHIFT_CNT_W-1:0] bit_count
);

  logic [pll_word_pkg::WORD_W-1:0]      next_shift_word;
  logic [pll_word_pkg::SHIFT_CNT_W-1:0] next_bit_count;

  ////////////////////////////////////////////////////////////////////////////
  // msb first; only the last 24 bits before the load strobe count
  always_comb begin
    next_shift_word = shift_word;
    next_bit_count  = bit_count;
    if (!link_load) begin
      next_shift_word = {shift_word[pll_word_pkg::WORD_W-2:0], link_data};
      if (bit_count != pll_word_pkg::SHIFT_CNT_W'(pll_word_pkg::WORD_W)) begin
        next_bit_count = bit_count + 1'h1;
      end
    end
  end

  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      shift_word <= '0;
      bit_count  <= '0;
    end else begin
      shift_word <= next_shift_word;
      bit_count  <= next_bit_count;
    end
  end

endmodule

// ### verification/pll_host_model.sv
// serial host model for the three-wire programming link
`timescale 1ns/1ps
module pll_host_model (
  // serial pins
  output logic link_clk,
  output logic link_data,
  output logic link_load
);
  initial begin
    link_clk  = 1'h0;
    link_data = 1'h0;
    link_load = 1'h0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // legal values come from caller
  task automatic send(input logic [23:0] w, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      link_data = w[i];
      #7.5 link_clk = 1'h1;
      #7.5 link_clk = 1'h0;
    end
    // clock stands still, data no longer valid
    link_data = ~link_data;
    #4 link_load = 1'h1;
    #60 link_load = 1'h0;
    #60;
  endtask
endmodule

// ### verification/pll_divider_word_decode_chk.sv
// concurrent checks on the decoder ports
`timescale 1ns/1ps
module pll_divider_word_decode_chk (
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        rst_b,
  // pins
  input wire logic        chip_enable,
  input wire logic        auto_power_up_field,
  // main loop
  input wire logic [10:0] main_feedback_count,
  input wire logic [5:0]  main_reference_count,
  input wire logic        main_loop_power_down,
  input wire logic        main_loop_active,
  input wire logic        main_count_illegal,
  input wire logic        main_word_loaded,
  input wire logic        ref_word_loaded,
  // aux loop
  input wire logic [16:0] aux_feedback_count,
  input wire logic [12:0] aux_program_count,
  input wire logic [3:0]  aux_swallow_count,
  input wire logic        aux_prescaler_16,
  input wire logic        aux_pump_gain,
  input wire logic        aux_pump_high_current,
  input wire logic        aux_loop_power_down,
  input wire logic        aux_pump_tristate,
  input wire logic        aux_count_illegal,
  input wire logic        aux_word_loaded
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////////////////////////////////////////
  chk_active_inverse: assert property (main_loop_active == !main_loop_power_down)
    else $error("active flag wrong");
  chk_aux_float: assert property (aux_pump_tristate == aux_loop_power_down)
    else $error("aux pump float wrong");
  chk_gain_current: assert property (aux_pump_high_current == aux_pump_gain)
    else $error("aux current wrong");
  chk_enable_wins: assert property (!chip_enable [*4] |-> main_loop_power_down)
    else $error("enable low not obeyed");
  chk_auto_up: assert property ((chip_enable && auto_power_up_field) [*5] |-> !main_loop_power_down)
    else $error("auto power up not obeyed");
  chk_main_prohib: assert property (main_word_loaded && (main_feedback_count <= 11'h041 ||
      main_feedback_count > 11'h7fe) |-> ##2 main_count_illegal)
    else $error("prohibited divide not flagged");
  chk_aux_split: assert property (aux_word_loaded |=> aux_program_count == aux_feedback_count[16:4] &&
      aux_swallow_count == (aux_prescaler_16 ? aux_feedback_count[3:0] : {1'h0, aux_feedback_count[2:0]}))
    else $error("aux split wrong");
  chk_aux_illegal: assert property (aux_word_loaded |-> ##2 aux_count_illegal ==
      (aux_program_count < 13'h0003 || aux_program_count < {9'h000, aux_swallow_count}))
    else $error("aux legality flag wrong");
  chk_pulse_single: assert property (main_word_loaded |=> !main_word_loaded)
    else $error("load pulse too long");
  chk_fields_hold: assert property ($changed(main_feedback_count) |-> main_word_loaded)
    else $error("main divide changed without load");
  chk_ref_nonzero: assert property (main_reference_count != 6'h00)
    else $error("reference divide zero");
  cover property (main_word_loaded);
  cover property (ref_word_loaded);
  cover property (aux_word_loaded && aux_count_illegal);
endmodule

// ### verification/pll_divider_word_decode_tb.sv
// self-checking bench for the divider word decoder
`timescale 1ns/1ps
module pll_divider_word_decode_tb;
  logic        ref_clk = 1'h0;
  logic        rst_b = 1'h0;
  logic        chip_enable = 1'h1;
  logic        auto_power_up_field = 1'h0;
  logic [1:0]  modulator_order = pll_word_pkg::ORDER_2;
  wire         link_clk, link_data, link_load;
  logic [10:0] main_feedback_count;
  logic [11:0] main_fraction_numerator, main_fraction_denominator;
  logic [5:0]  main_reference_count;
  logic [16:0] aux_feedback_count;
  logic [12:0] aux_program_count;
  logic [3:0]  aux_swallow_count;
  logic        main_loop_power_down, main_loop_active, main_pump_tristate, main_count_illegal;
  logic        aux_prescaler_16, aux_pump_gain, aux_pump_high_current, aux_loop_power_down;
  logic        aux_pump_tristate, aux_count_illegal, main_word_loaded, ref_word_loaded, aux_word_loaded;
  int          n_errors = 0, checks_done = 0, n_main = 0, n_ref = 0, n_aux = 0;
  always #5 ref_clk = ~ref_clk;
  pll_host_model host (.link_clk, .link_data, .link_load);
  pll_divider_word_decode DUT (.ref_clk, .rst_b, .link_clk, .link_data, .link_load, .chip_enable,
    .auto_power_up_field, .modulator_order, .main_feedback_count, .main_fraction_numerator,
    .main_fraction_denominator, .main_reference_count, .main_loop_power_down, .main_loop_active,
    .main_pump_tristate, .main_count_illegal, .aux_feedback_count, .aux_program_count, .aux_swallow_count,
    .aux_prescaler_16, .aux_pump_gain, .aux_pump_high_current, .aux_loop_power_down, .aux_pump_tristate,
    .aux_count_illegal, .main_word_loaded, .ref_word_loaded, .aux_word_loaded);
  // pulses stand one cycle, so count them as they pass
  always @(posedge ref_clk) begin
    n_main += (main_word_loaded === 1'h1);
    n_ref += (ref_word_loaded === 1'h1);
    n_aux += (aux_word_loaded === 1'h1);
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    $display("checks=%0d errors=%0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic drive(input logic en, input logic up);
    @(posedge ref_clk);
    #1 chip_enable = en;
    auto_power_up_field = up;
    repeat (6) @(posedge ref_clk);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_short;
    chk(main_reference_count, 6'h01);
    chk({main_loop_power_down, main_pump_tristate, aux_pump_tristate, main_feedback_count}, 14'h3800);
    host.send(24'h000000, 8);
    chk(n_main + n_ref + n_aux, 0);
    $display("test reset_short done");
  endtask
  task automatic t_main;
    logic [10:0] nv [5] = '{11'h044, 11'h7fe, 11'h041, 11'h042, 11'h7fb};
    logic [11:0] fv [5] = '{12'ha5c, 12'hfff, 12'h001, 12'h800, 12'h3c3};
    logic [1:0]  ov [5] = '{2'h1, 2'h1, 2'h1, 2'h2, 2'h3};
    logic        iv [5] = '{1'h0, 1'h0, 1'h1, 1'h1, 1'h1};
    for (int i = 0; i < 5; i++) begin
      @(posedge ref_clk);
      #1 modulator_order = ov[i];
      host.send({nv[i], fv[i], 1'h0}, 24);
      chk(main_feedback_count, nv[i]);
      chk(main_fraction_numerator, fv[i]);
      chk(main_count_illegal, iv[i]);
    end
    chk(n_main, 5);
    $display("test main done");
  endtask
  task automatic t_ref;
    host.send({2'h1, 6'h3f, 12'h5a5, 4'h1}, 24);
    chk({main_reference_count, main_fraction_denominator}, 18'h3f5a5);
    chk({main_loop_power_down, main_loop_active, main_pump_tristate}, 3'h2);
    host.send({2'h3, 6'h00, 12'h00f, 4'h1}, 24);
    chk(main_reference_count, 6'h3f);
    chk(main_loop_power_down, 1'h1);
    drive(1'h1, 1'h1);
    chk(main_loop_power_down, 1'h0);
    drive(1'h0, 1'h1);
    chk(main_loop_power_down, 1'h1);
    drive(1'h1, 1'h0);
    chk({main_loop_power_down, n_ref[3:0]}, 5'h12);
    $display("test ref done");
  endtask
  task automatic t_aux;
    logic [19:0] aw [3] = '{20'h600f5, 20'h80033, 20'h4002f};
    logic        iv [3] = '{1'h0, 1'h0, 1'h1};
    logic [16:0] n;
    logic        p;
    for (int i = 0; i < 3; i++) begin
      n = aw[i][16:0];
      p = aw[i][18];
      host.send({aw[i], 4'h3}, 24);
      chk(aux_feedback_count, n);
      chk({aux_program_count, aux_swallow_count}, {n[16:4], p ? n[3:0] : {1'h0, n[2:0]}});
      chk({aux_loop_power_down, aux_prescaler_16, aux_pump_gain}, aw[i][19:17]);
      chk({aux_pump_tristate, aux_pump_high_current}, {aw[i][19], aw[i][17]});
      chk(aux_count_illegal, iv[i]);
    end
    host.send(24'hfffff5, 24);
    chk({n_aux[3:0], n_main[3:0], aux_feedback_count}, {8'h35, 17'h0002f});
    $display("test aux done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    fork
      host.send(24'h000000, 2);
      repeat (16) @(posedge ref_clk);
    join
    #1 rst_b = 1'h1;
    repeat (3) @(posedge ref_clk);
    #1;
    t_reset_short();
    t_main();
    t_ref();
    t_aux();
    conclude();
  end
  initial begin
    #100000;
    n_errors++;
    conclude();
  end
endmodule
bind pll_divider_word_decode pll_divider_word_decode_chk u_chk (.ref_clk, .rst_b, .chip_enable,
  .auto_power_up_field, .main_feedback_count, .main_reference_count, .main_loop_power_down,
  .main_loop_active, .main_count_illegal, .main_word_loaded, .ref_word_loaded, .aux_feedback_count,
  .aux_program_count, .aux_swallow_count, .aux_prescaler_16, .aux_pump_gain, .aux_pump_high_current,
  .aux_loop_power_down, .aux_pump_tristate, .aux_count_illegal, .aux_word_loaded);
